//--- bench/pfcs_host_model.sv
// Host bridge model issuing config cycles to the register bank.
// Assumes strobes sampled on rising ref_clk, answer one cycle later.
`timescale 1ns/1ps

module pfcs_host_model (
   input wire logic ref_clk,
   output logic cfg_wr,
   output logic cfg_rd,
   output logic [7:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid
);
   // ----------------
   // Config cycles
   // ----------------
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end
   // Released address and write data flip, so a stale value never passes
   task automatic idle();
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = ~cfg_addr;
      cfg_wdata = ~cfg_wdata;
   endtask
   // Ones clear status bits, zeros keep them
   task automatic wr(input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d);
      @(negedge ref_clk);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(negedge ref_clk);
      idle();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic ok);
      @(negedge ref_clk);
      cfg_rd = 1'b1;
      cfg_addr = a;
      cfg_be = 4'hf;
      @(negedge ref_clk);
      ok = cfg_rvalid;
      d = cfg_rdata;
      idle();
   endtask
endmodule

//--- bench/test_pci_function_cmd_status_regs.sv
// Self-checking bench for the command/status register bank.
// Assumes config cycles come from the host model, events from here.
`timescale 1ns/1ps

module test_pci_function_cmd_status_regs;
   logic ref_clk, reset_n, master_active, int_source, master_req_in;
   logic mem_hit, cfg_wr, cfg_rd, cfg_rvalid, master_req_out, mem_claim;
   logic use_mwi, sys_error_out, parity_error_out, int_out, rd_ok;
   logic back_to_back_en, stepping_ctl, palette_snoop_en, io_space_en;
   logic mem_response_en, bus_master_en, invalidate_write_en;
   logic parity_response_en, sys_error_drive_en;
   logic [5:0] ev;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [1:0] devsel_timing;
   logic [31:0] cfg_wdata, cfg_rdata, rd_data;
   int n_mismatch = 0;
   int check_count = 0;

   pfcs_regs dut (.ref_clk, .reset_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
      .cfg_wdata, .cfg_rdata, .cfg_rvalid, .addr_parity_err(ev[0]),
      .data_parity_err(ev[1]), .master_abort_evt(ev[2]),
      .target_abort_evt(ev[3]), .target_abort_sig_evt(ev[4]),
      .perr_observed(ev[5]), .master_active, .int_source, .master_req_in,
      .mem_hit, .master_req_out, .mem_claim, .use_mwi, .sys_error_out,
      .parity_error_out, .int_out, .devsel_timing, .back_to_back_en,
      .stepping_ctl, .palette_snoop_en, .io_space_en, .mem_response_en,
      .bus_master_en, .invalidate_write_en, .parity_response_en,
      .sys_error_drive_en);
   pfcs_host_model host (.ref_clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
      .cfg_wdata, .cfg_rdata, .cfg_rvalid);

   // ----------------
   // Checks
   // ----------------
   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
      host.rd(a, rd_data, rd_ok);
      check("read valid", 32'h1, {31'h0, rd_ok});
      check(what, exp, rd_data);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(negedge ref_clk);
      reset_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      reset_n = 1'b1;
   endtask

   // ----------------
   // Scenarios
   // ----------------
   task automatic t_cmd_bits();
      rd_chk("reset dword", 8'h04, 32'h0230_0000);
      check("timing", 32'h1, {30'h0, devsel_timing});
      host.wr(8'h04, 4'hf, 32'hffff_ffff);
      rd_chk("cmd ones", 8'h04, 32'h0230_0556);
      check("fixed outs", 32'h0, {28'h0, back_to_back_en, stepping_ctl,
         palette_snoop_en, io_space_en});
      check("en outs", 32'h1f, {27'h0, mem_response_en, bus_master_en,
         invalidate_write_en, parity_response_en,
         sys_error_drive_en});
      host.wr(8'h04, 4'h1, 32'h0000_0000);
      host.wr(8'h08, 4'hf, 32'h0000_0000);
      rd_chk("low byte", 8'h04, 32'h0230_0500);
      rd_chk("unmapped", 8'h08, 32'h0000_0000);
   endtask
   task automatic t_gating();
      host.wr(8'h04, 4'h3, 32'h0000_0000);
      master_req_in = 1'b1;
      mem_hit = 1'b1;
      @(negedge ref_clk);
      check("gated", 32'h0, {29'h0, master_req_out, mem_claim,
         use_mwi});
      host.wr(8'h04, 4'h3, 32'h0000_0004);
      check("master only", 32'h4, {29'h0, master_req_out, mem_claim,
         use_mwi});
      host.wr(8'h04, 4'h3, 32'h0000_0016);
      check("enabled", 32'h7, {29'h0, master_req_out, mem_claim,
         use_mwi});
      host.wr(8'h04, 4'h3, 32'h0000_0006);
      check("plain wr", 32'h6, {29'h0, master_req_out, mem_claim,
         use_mwi});
      master_req_in = 1'b0;
      mem_hit = 1'b0;
   endtask
   task automatic t_events();
      logic [15:0] tab [6];
      logic [15:0] e;
      logic [15:0] c;
      tab = '{16'hc000, 16'h8000, 16'h2000, 16'h1000, 16'h0800, 16'h0100};
      master_active = 1'b1;
      for (int en = 0; en < 2; en++) begin
         c = en ? 16'h0140 : 16'h0000;
         host.wr(8'h04, 4'h3, {16'h0, c});
         for (int i = 0; i < 6; i++) begin
            e = !en && i == 0 ? 16'h8000 : !en && i == 5 ? 16'h0 : tab[i];
            @(negedge ref_clk);
            ev[i] = 1'b1;
            @(negedge ref_clk);
            ev[i] = 1'b0;
            check("serr", {31'h0, en == 1 && i == 0},
               {31'h0, sys_error_out});
            check("perr", {31'h0, en == 1 && i == 1},
               {31'h0, parity_error_out});
            rd_chk("event sts", 8'h04, {e | 16'h0230, c});
            host.wr(8'h04, 4'hc, 32'hffff_0000);
            rd_chk("cleared", 8'h04, {16'h0230, c});
         end
      end
      master_active = 1'b0;
      @(negedge ref_clk);
      ev[5] = 1'b1;
      @(negedge ref_clk);
      ev[5] = 1'b0;
      rd_chk("not master", 8'h04, 32'h0230_0140);
   endtask
   task automatic t_set_wins();
      fork
         host.wr(8'h04, 4'hc, 32'h2000_0000);
         begin
            @(negedge ref_clk);
            ev[2] = 1'b1;
            @(negedge ref_clk);
            ev[2] = 1'b0;
         end
      join
      rd_chk("set wins", 8'h04, 32'h2230_0140);
      host.wr(8'h04, 4'hc, 32'h2000_0000);
   endtask
   task automatic t_intr();
      @(negedge ref_clk);
      int_source = 1'b1;
      repeat (2) @(negedge ref_clk);
      check("int out", 32'h1, {31'h0, int_out});
      host.wr(8'h04, 4'h3, 32'h0000_0400);
      @(negedge ref_clk);
      check("masked", 32'h0, {31'h0, int_out});
      rd_chk("pending", 8'h04, 32'h0238_0400);
      int_source = 1'b0;
      host.wr(8'h04, 4'h3, 32'h0000_0556);
      do_reset();
      rd_chk("mid reset", 8'h04, 32'h0230_0000);
   endtask

   // ----------------
   // Run
   // ----------------
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      reset_n = 1'b0;
      ev = 6'h00;
      master_active = 1'b0;
      int_source = 1'b0;
      master_req_in = 1'b0;
      mem_hit = 1'b0;
      do_reset();
      t_cmd_bits();
      t_gating();
      t_events();
      t_set_wins();
      t_intr();
      give_verdict();
   end
   // Whole run is about 160 cycles; this cuts a hang
   initial begin
      #20000;
      n_mismatch++;
      give_verdict();
   end
endmodule

//--- logic/pfcs_cfg.svh
// Offsets, bit positions and fixed values of the command/status pair.
// Assumes byte offsets within a 256-byte configuration space.
`ifndef PFCS_CFG_SVH
`define PFCS_CFG_SVH

// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define PFCS_CMD_OFS 8'h04
`define PFCS_STS_OFS 8'h06

// ---------------------------------------------------------------
// Command bits
// ---------------------------------------------------------------
`define PFCS_CMD_IO 0
`define PFCS_CMD_MEM 1
`define PFCS_CMD_BME 2
`define PFCS_CMD_SPC 3
`define PFCS_CMD_MWI 4
`define PFCS_CMD_VGA 5
`define PFCS_CMD_PERR 6
`define PFCS_CMD_STEP 7
`define PFCS_CMD_SERR 8
`define PFCS_CMD_FBB 9
`define PFCS_CMD_INTD 10
`define PFCS_CMD_WMASK 16'h0556
`define PFCS_CMD_RST 16'h0000

// ---------------------------------------------------------------
// Status bits
// ---------------------------------------------------------------
`define PFCS_STS_INT 3
`define PFCS_STS_DPR 8
`define PFCS_STS_STA 11
`define PFCS_STS_RTA 12
`define PFCS_STS_RMA 13
`define PFCS_STS_SSE 14
`define PFCS_STS_DPE 15
`define PFCS_STS_W1C 16'hf900
`define PFCS_STS_FIXED 16'h0230
`define PFCS_DEVSEL_MED 2'h1
`define PFCS_STS_RST 16'h0000

`endif

//--- logic/pfcs_pkg.sv
// Types shared by the command/status register bank.
// Assumes the bit layout of pfcs_cfg.svh.
package pfcs_pkg;

   // ------------------------------------------------------------
   // Whole state of the bank
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] cmd;
      logic [15:0] sts;
      logic int_pend;
      logic intx;
      logic serr;
      logic perr;
      logic rvalid;
      logic [31:0] rdata;
   } pfcs_state_t;

endpackage

//--- logic/pfcs_regs.sv
// Command and status registers of a PCI function, with the gating
// they apply to the function's bus behaviour.
// Assumes config cycles arrive decoded, one dword, on ref_clk.
//
// How it works
// - command bits 15 to 11 read zero and ignore writes.
// - interrupt mask bit set blocks interrupt output; resets to zero.
// - no fast back-to-back; its command bit reads zero.
// - system error output only when enabled, after address parity error.
// - no stepping; stepping control bit hardwired zero.
// - parity error output only while parity response enabled.
// - no palette snooping; its enable bit reads zero.
// - invalidate-write bit selects write-and-invalidate commands as master.
// - special cycles ignored; special cycle bit reads zero.
// - master cycles only while bus master enable is set.
// - memory cycles claimed only while memory response enable set.
// - no I/O space decode; I/O enable bit reads zero.
// - detected parity status set on address or data parity error.
// - signaled system error status set when system error driven.
// - received master abort status set on master abort.
// - received target abort status set on target abort of our cycle.
// - signaled target abort status set when we target-abort.
// - select timing field reads medium; select asserted at medium.
// - data parity reported set on parity seen as master, enabled.
// - fast clock capable and capability list bits read one.
// - interrupt pending follows source; output needs mask clear.
// - status bits 2 to 0 read zero.
`timescale 1ns/1ps
`include "pfcs_cfg.svh"

module pfcs_regs
   import pfcs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic addr_parity_err,
   input wire logic data_parity_err,
   input wire logic perr_observed,
   input wire logic master_active,
   input wire logic master_abort_evt,
   input wire logic target_abort_evt,
   input wire logic target_abort_sig_evt,
   input wire logic int_source,
   input wire logic master_req_in,
   input wire logic mem_hit,
   output logic master_req_out,
   output logic mem_claim,
   output logic use_mwi,
   output logic sys_error_out,
   output logic parity_error_out,
   output logic int_out,
   output logic [1:0] devsel_timing,
   output logic back_to_back_en,
   output logic stepping_ctl,
   output logic palette_snoop_en,
   output logic io_space_en,
   output logic mem_response_en,
   output logic bus_master_en,
   output logic invalidate_write_en,
   output logic parity_response_en,
   output logic sys_error_drive_en
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   pfcs_state_t s_q;
   pfcs_state_t s_d;
   logic hit;
   logic [15:0] cmd_new;
   logic [15:0] clr;
   logic [15:0] set;
   logic [15:0] sts_view;

   // Both registers share dword 1; offset 0x06 is its upper half
   assign hit = (cfg_addr[7:2] == 6'(`PFCS_CMD_OFS >> 2));

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      cmd_new = s_q.cmd;
      clr = 16'h0000;
      set = 16'h0000;
      if (cfg_wr && hit) begin
         if (cfg_be[0]) begin
            cmd_new[7:0] = cfg_wdata[7:0];
         end
         if (cfg_be[1]) begin
            cmd_new[15:8] = cfg_wdata[15:8];
         end
         if (cfg_be[2]) begin
            clr[7:0] = cfg_wdata[23:16];
         end
         if (cfg_be[3]) begin
            clr[15:8] = cfg_wdata[31:24];
         end
      end
      // Read-only and hardwired positions never store
      s_d.cmd = cmd_new & `PFCS_CMD_WMASK;

      set[`PFCS_STS_DPE] = addr_parity_err | data_parity_err;
      set[`PFCS_STS_SSE] = s_q.serr;
      set[`PFCS_STS_RMA] = master_abort_evt;
      set[`PFCS_STS_RTA] = target_abort_evt;
      set[`PFCS_STS_STA] = target_abort_sig_evt;
      set[`PFCS_STS_DPR] = perr_observed & master_active
         & s_q.cmd[`PFCS_CMD_PERR];
      // Set wins over a clear in the same cycle
      s_d.sts = ((s_q.sts & ~clr) | set) & `PFCS_STS_W1C;

      // Pending ignores the mask; only the pin is gated
      s_d.int_pend = int_source;
      s_d.intx = s_q.int_pend & ~s_q.cmd[`PFCS_CMD_INTD];
      s_d.serr = addr_parity_err & s_q.cmd[`PFCS_CMD_SERR];
      s_d.perr = data_parity_err & s_q.cmd[`PFCS_CMD_PERR];

      s_d.rvalid = cfg_rd;
      if (cfg_rd && hit) begin
         s_d.rdata = {sts_view, s_q.cmd};
      end else if (cfg_rd) begin
         s_d.rdata = 32'h0000_0000;
      end
   end

   // Fixed capability bits merged at read time
   always_comb begin
      sts_view = s_q.sts | `PFCS_STS_FIXED;
      sts_view[`PFCS_STS_INT] = s_q.int_pend;
   end

   // ------------------------------------------------------------
   // Register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign cfg_rdata = s_q.rdata;
   assign cfg_rvalid = s_q.rvalid;
   assign mem_response_en = s_q.cmd[`PFCS_CMD_MEM];
   assign bus_master_en = s_q.cmd[`PFCS_CMD_BME];
   assign invalidate_write_en = s_q.cmd[`PFCS_CMD_MWI];
   assign parity_response_en = s_q.cmd[`PFCS_CMD_PERR];
   assign sys_error_drive_en = s_q.cmd[`PFCS_CMD_SERR];
   assign back_to_back_en = s_q.cmd[`PFCS_CMD_FBB];
   assign stepping_ctl = s_q.cmd[`PFCS_CMD_STEP];
   assign palette_snoop_en = s_q.cmd[`PFCS_CMD_VGA];
   assign io_space_en = s_q.cmd[`PFCS_CMD_IO];
   // Handshake gates stay combinational so no cycle is lost
   assign master_req_out = master_req_in & bus_master_en;
   assign mem_claim = mem_hit & mem_response_en;
   assign use_mwi = invalidate_write_en;
   assign sys_error_out = s_q.serr;
   assign parity_error_out = s_q.perr;
   assign int_out = s_q.intx;
   assign devsel_timing = `PFCS_DEVSEL_MED;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_rsvd_cmd_zero: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_rvalid |-> cfg_rdata[15:11] == 5'h00)
      else $error("reserved command bits not zero");

   a_int_mask_gate: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      $past(s_q.cmd[`PFCS_CMD_INTD]) |-> !int_out)
      else $error("interrupt asserted while masked");

   a_int_follow: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (int_source && !s_q.cmd[`PFCS_CMD_INTD]) [*2] |=> int_out)
      else $error("interrupt not delivered");

   a_hardwired_zero: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_rvalid && $past(hit) |-> cfg_rdata[9] == 1'b0
         && cfg_rdata[7] == 1'b0 && cfg_rdata[5] == 1'b0
         && cfg_rdata[3] == 1'b0 && cfg_rdata[0] == 1'b0)
      else $error("hardwired command bit not zero");

   a_serr_gate: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      sys_error_out == $past(addr_parity_err && sys_error_drive_en))
      else $error("system error output wrong");

   a_perr_gate: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      parity_error_out == $past(data_parity_err && parity_response_en))
      else $error("parity error output wrong");

   a_dpe_set: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (addr_parity_err || data_parity_err) |=> s_q.sts[`PFCS_STS_DPE])
      else $error("detected parity status not set");

   a_sse_set: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      sys_error_out |=> s_q.sts[`PFCS_STS_SSE])
      else $error("signaled system error not set");

   a_rma_set: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      master_abort_evt |=> s_q.sts[`PFCS_STS_RMA])
      else $error("master abort status not set");

   a_caps_fixed: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_rvalid && $past(hit) |-> cfg_rdata[26:25] == 2'h1
         && cfg_rdata[21:20] == 2'h3 && cfg_rdata[18:16] == 3'h0)
      else $error("fixed status fields wrong");

   a_w1c_clear: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_wr && hit && cfg_be[3] && cfg_wdata[31]
         && !addr_parity_err && !data_parity_err
      |=> !s_q.sts[`PFCS_STS_DPE])
      else $error("write one did not clear");

   a_cmd_hold: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      !(cfg_wr && hit) |=> $stable(s_q.cmd))
      else $error("command changed without write");

   a_cmd_write: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_wr && hit && cfg_be[1]
      |=> s_q.cmd[`PFCS_CMD_INTD] == $past(cfg_wdata[`PFCS_CMD_INTD]))
      else $error("interrupt mask write lost");

   a_rta_set: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      target_abort_evt |=> s_q.sts[`PFCS_STS_RTA])
      else $error("received target abort status not set");

   a_sta_set: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      target_abort_sig_evt |=> s_q.sts[`PFCS_STS_STA])
      else $error("signaled target abort status not set");

   a_dpr_set: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      perr_observed && master_active && parity_response_en
      |=> s_q.sts[`PFCS_STS_DPR])
      else $error("data parity reported not set");

   // Only our own master cycles may report data parity
   a_dpr_idle: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      !s_q.sts[`PFCS_STS_DPR] && !master_active
      |=> !s_q.sts[`PFCS_STS_DPR])
      else $error("data parity reported while not master");

   a_mwi_select: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_wr && hit && cfg_be[0]
      |=> use_mwi == $past(cfg_wdata[`PFCS_CMD_MWI]))
      else $error("write command kind not as programmed");

   a_mem_off: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_wr && hit && cfg_be[0] && !cfg_wdata[`PFCS_CMD_MEM]
      |=> !mem_claim)
      else $error("memory cycle claimed while disabled");

   a_master_off: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_wr && hit && cfg_be[0] && !cfg_wdata[`PFCS_CMD_BME]
      |=> !master_req_out)
      else $error("master cycle started while disabled");

   a_unused_zero: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      !io_space_en && !back_to_back_en && !stepping_ctl
         && !palette_snoop_en)
      else $error("unsupported feature enabled");

   a_sse_gate: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      !s_q.sts[`PFCS_STS_SSE] && !sys_error_out
      |=> !s_q.sts[`PFCS_STS_SSE])
      else $error("system error status set without driving");

   // Pending bit is one cycle behind the source, read one more
   a_pend_view: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_rvalid && $past(hit) |-> cfg_rdata[16 + `PFCS_STS_INT]
         == $past(int_source, 2))
      else $error("interrupt pending bit wrong");

endmodule
